// >>> core/dphc_cfg.svh
`ifndef DPHC_CFG_SVH
`define DPHC_CFG_SVH
// What this block does
// - After reset the JTAG port is active.
// - High run, 0xE79E, high run selects serial-wire.
// - High run, 0xE73C, high run reselects JTAG.
// - Serial wire shares mode and clock pins.
// - Trace output drives the data-out pin.
// - Without reset pin, TAP reset held inactive.
// - Serial-wire or off releases the unused pins.
// - Boundary TAP, 5-bit IR, precedes core TAP.
// - Boundary TAP returns fixed identification code.
// - Debug state cleared by power-on reset only.
// - TAP reset pin resets only the TAP.
// - Halt request survives system reset, then halts.
// - Standby hold keeps clocks, exit resets system.
// - Deep-sleep hold keeps clocks on internal oscillator.
// - Sleep hold keeps processor bus clock running.
// - Timer hold bits freeze counters while halted.
// - Bus hold bits freeze SMBus timeout while halted.
// - Watchdog hold bits stop counter clock while halted.
// - CAN hold bits stop receive while halted.
// - Bit 5 allocates the trace pins.
// - Control register power-reset only, reserved bits zero.
// - Identification register is a read-only constant.

// ----------------------------------------
// Register offsets.
// ----------------------------------------
`define DPHC_OFS_IDENTITY 8'h00
`define DPHC_OFS_HOLD_CTL 8'h04
`define DPHC_OFS_PIN_CFG 8'h08
`define DPHC_OFS_STATUS 8'h0C

// ----------------------------------------
// Field positions and reset values.
// ----------------------------------------
`define DPHC_HOLD_CTL_RESET 32'h00000000
`define DPHC_HOLD_CTL_WMASK 32'hFE7FFF2F
`define DPHC_BIT_SLEEP_KEEP 0
`define DPHC_BIT_DEEPSLEEP_KEEP 1
`define DPHC_BIT_STANDBY_KEEP 2
`define DPHC_BIT_TRACE_EN 5
`define DPHC_BIT_FREE_WDG 8
`define DPHC_BIT_WINDOW_WDG 9
`define DPHC_PINCFG_NO_TRST 0
`define DPHC_PINCFG_OFF 1
`define DPHC_PINCFG_RESET 2'h0

// ----------------------------------------
// Link sequences and scan chain.
// ----------------------------------------
`define DPHC_SEQ_HIGH_MIN 50
`define DPHC_SEQ_TO_SWD 16'hE79E
`define DPHC_SEQ_TO_JTAG 16'hE73C
`define DPHC_IR_BYPASS 5'h1F
`define DPHC_IR_IDCODE 5'h01
`define DPHC_IR_CAPTURE 5'h01
`endif

// >>> core/dphc_pkg.sv
package dphc_pkg;
  typedef enum logic [3:0] {
    DPHC_TLR, DPHC_RTI, DPHC_SEL_DR, DPHC_CAP_DR, DPHC_SH_DR, DPHC_EX1_DR, DPHC_PAU_DR, DPHC_EX2_DR,
    DPHC_UPD_DR, DPHC_SEL_IR, DPHC_CAP_IR, DPHC_SH_IR, DPHC_EX1_IR, DPHC_PAU_IR, DPHC_EX2_IR, DPHC_UPD_IR
  } dphc_tap_e;

  typedef enum logic {DPHC_PORT_JTAG, DPHC_PORT_SWD} dphc_port_e;

  typedef enum logic [1:0] {DPHC_SEQ_WAIT, DPHC_SEQ_PATTERN, DPHC_SEQ_TAIL} dphc_seq_e;

  typedef struct packed {
    dphc_tap_e state;
  } dphc_tap_s;

  typedef struct packed {
    logic [2:0] tck_sync;
    logic [1:0] tms_sync;
    logic [1:0] tdi_sync;
    logic [1:0] trst_sync;
    dphc_port_e port;
    dphc_seq_e seq;
    logic [7:0] high_cnt;
    logic [3:0] bit_cnt;
    logic [15:0] pat;
    logic [4:0] ir_sh;
    logic [4:0] ir;
    logic [31:0] dr_sh;
    logic bsd_out;
    logic dout;
    logic dout_oe;
    logic swdio_out;
    logic swdio_oe;
    logic [31:0] ctl;
    logic [1:0] pincfg;
    logic halt_pend;
    logic standby_prev;
    logic standby_rst;
    logic [31:0] rdata;
  } dphc_top_s;
endpackage

// >>> core/dphc_tap_if.sv
`timescale 1ns/1ns
interface dphc_tap_if;
  logic tck_rise;
  logic tms;
  logic tap_reset;
  dphc_pkg::dphc_tap_e state;

  modport ctrl (input tck_rise, input tms, input tap_reset, output state);
  modport user (output tck_rise, output tms, output tap_reset, input state);
endinterface

// >>> core/dphc_tap_ctrl.sv
`timescale 1ns/1ns
module dphc_tap_ctrl (
  input wire logic clk_sys,
  input wire logic rst,
  dphc_tap_if.ctrl tap
);
  dphc_pkg::dphc_tap_s s_ff;
  dphc_pkg::dphc_tap_s nxt_s;

  function automatic dphc_pkg::dphc_tap_e tap_next(input dphc_pkg::dphc_tap_e st, input logic tms);
    case (st)
      dphc_pkg::DPHC_TLR: tap_next = tms ? dphc_pkg::DPHC_TLR : dphc_pkg::DPHC_RTI;
      dphc_pkg::DPHC_RTI: tap_next = tms ? dphc_pkg::DPHC_SEL_DR : dphc_pkg::DPHC_RTI;
      dphc_pkg::DPHC_SEL_DR: tap_next = tms ? dphc_pkg::DPHC_SEL_IR : dphc_pkg::DPHC_CAP_DR;
      dphc_pkg::DPHC_CAP_DR: tap_next = tms ? dphc_pkg::DPHC_EX1_DR : dphc_pkg::DPHC_SH_DR;
      dphc_pkg::DPHC_SH_DR: tap_next = tms ? dphc_pkg::DPHC_EX1_DR : dphc_pkg::DPHC_SH_DR;
      dphc_pkg::DPHC_EX1_DR: tap_next = tms ? dphc_pkg::DPHC_UPD_DR : dphc_pkg::DPHC_PAU_DR;
      dphc_pkg::DPHC_PAU_DR: tap_next = tms ? dphc_pkg::DPHC_EX2_DR : dphc_pkg::DPHC_PAU_DR;
      dphc_pkg::DPHC_EX2_DR: tap_next = tms ? dphc_pkg::DPHC_UPD_DR : dphc_pkg::DPHC_SH_DR;
      dphc_pkg::DPHC_UPD_DR: tap_next = tms ? dphc_pkg::DPHC_SEL_DR : dphc_pkg::DPHC_RTI;
      dphc_pkg::DPHC_SEL_IR: tap_next = tms ? dphc_pkg::DPHC_TLR : dphc_pkg::DPHC_CAP_IR;
      dphc_pkg::DPHC_CAP_IR: tap_next = tms ? dphc_pkg::DPHC_EX1_IR : dphc_pkg::DPHC_SH_IR;
      dphc_pkg::DPHC_SH_IR: tap_next = tms ? dphc_pkg::DPHC_EX1_IR : dphc_pkg::DPHC_SH_IR;
      dphc_pkg::DPHC_EX1_IR: tap_next = tms ? dphc_pkg::DPHC_UPD_IR : dphc_pkg::DPHC_PAU_IR;
      dphc_pkg::DPHC_PAU_IR: tap_next = tms ? dphc_pkg::DPHC_EX2_IR : dphc_pkg::DPHC_PAU_IR;
      dphc_pkg::DPHC_EX2_IR: tap_next = tms ? dphc_pkg::DPHC_UPD_IR : dphc_pkg::DPHC_SH_IR;
      dphc_pkg::DPHC_UPD_IR: tap_next = tms ? dphc_pkg::DPHC_SEL_DR : dphc_pkg::DPHC_RTI;
      default: tap_next = dphc_pkg::DPHC_TLR;
    endcase
  endfunction

  // ----------------------------------------
  // State update on each sampled rising link clock edge.
  // ----------------------------------------
  always_comb begin
    nxt_s = s_ff;
    if (tap.tap_reset) begin
      nxt_s.state = dphc_pkg::DPHC_TLR;
    end else if (tap.tck_rise) begin
      nxt_s.state = tap_next(s_ff.state, tap.tms);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_ff <= '{state: dphc_pkg::DPHC_TLR};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tap.state = s_ff.state;
endmodule // dphc_tap_ctrl

// >>> core/dphc_top.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`include "dphc_cfg.svh"
module dphc_top #(
  parameter int unsigned SEQ_HIGH_MIN = `DPHC_SEQ_HIGH_MIN,
  parameter logic [31:0] BSCAN_IDCODE = 32'h00001001,
  parameter logic [31:0] ID_REG_VALUE = 32'h00002001
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sys_reset,
  input wire logic dbg_clock_pin,
  input wire logic dbg_mode_select_pin_in,
  output logic dbg_mode_select_pin_out,
  output logic dbg_mode_select_pin_oe,
  input wire logic dbg_data_in_pin,
  output logic dbg_data_out_pin,
  output logic dbg_data_out_pin_oe,
  input wire logic tap_reset_n_pin,
  output logic own_clock_pin,
  output logic own_mode_select_pin,
  output logic own_data_in_pin,
  output logic own_data_out_pin,
  output logic own_tap_reset_pin,
  output logic swd_active,
  output logic link_clk_rise,
  output logic link_clk_fall,
  output logic link_mode_sel,
  output logic core_tap_tdi,
  input wire logic core_tap_tdo,
  input wire logic swd_dio_out,
  input wire logic swd_dio_oe,
  input wire logic async_trace_out,
  input wire logic dbg_halt_req,
  input wire logic core_halted,
  output logic core_halt_req,
  input wire logic in_sleep,
  input wire logic in_deepsleep,
  input wire logic in_standby,
  output logic keep_bus_clock,
  output logic clock_from_internal_rc_8mhz_clock,
  output logic standby_exit_reset,
  output logic [14:0] timer_freeze,
  output logic [2:0] smbus_timeout_freeze,
  output logic [2:0] can_rx_freeze,
  output logic free_watchdog_freeze,
  output logic window_watchdog_freeze,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  dphc_pkg::dphc_top_s s_ff;
  dphc_pkg::dphc_top_s nxt_s;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic jtag_on;
  logic trace_on;
  logic [15:0] pat_next;
  logic [7:0] high_min;
  dphc_tap_if tap_if ();

  // ----------------------------------------
  // Parameter checks.
  // ----------------------------------------
  if (SEQ_HIGH_MIN < 1 || SEQ_HIGH_MIN > 255) begin : g_chk
    $error("SEQ_HIGH_MIN must lie in 1 to 255.");
  end
  if (BSCAN_IDCODE[0] != 1'b1) begin : g_chk_id
    $error("BSCAN_IDCODE bit 0 must be one.");
  end

  // ----------------------------------------
  // Link edge detection and shared decodes.
  // ----------------------------------------
  assign high_min = 8'(SEQ_HIGH_MIN);
  assign tck_rise = s_ff.tck_sync[1] & ~s_ff.tck_sync[2] & ~s_ff.pincfg[`DPHC_PINCFG_OFF];
  assign tck_fall = ~s_ff.tck_sync[1] & s_ff.tck_sync[2] & ~s_ff.pincfg[`DPHC_PINCFG_OFF];
  assign tms = s_ff.tms_sync[1];
  assign tdi = s_ff.tdi_sync[1];
  assign jtag_on = (s_ff.port == dphc_pkg::DPHC_PORT_JTAG) & ~s_ff.pincfg[`DPHC_PINCFG_OFF];
  assign trace_on = s_ff.ctl[`DPHC_BIT_TRACE_EN];
  assign pat_next = {tms, s_ff.pat[15:1]};

  assign tap_if.tck_rise = tck_rise & jtag_on;
  assign tap_if.tms = tms;
  assign tap_if.tap_reset = jtag_on & ~s_ff.pincfg[`DPHC_PINCFG_NO_TRST] & ~s_ff.trst_sync[1];

  dphc_tap_ctrl u_tap (
    .clk_sys(clk_sys),
    .rst(rst),
    .tap(tap_if.ctrl)
  );

  // ----------------------------------------
  // Next-state logic.
  // ----------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.tck_sync = {s_ff.tck_sync[1:0], dbg_clock_pin};
    nxt_s.tms_sync = {s_ff.tms_sync[0], dbg_mode_select_pin_in};
    nxt_s.tdi_sync = {s_ff.tdi_sync[0], dbg_data_in_pin};
    nxt_s.trst_sync = {s_ff.trst_sync[0], tap_reset_n_pin};

    // Port switch sequence detector.
    if (tck_rise) begin
      case (s_ff.seq)
        dphc_pkg::DPHC_SEQ_WAIT: begin
          if (tms) begin
            if (s_ff.high_cnt < high_min) begin
              nxt_s.high_cnt = s_ff.high_cnt + 8'h01;
            end
          end else begin
            if (s_ff.high_cnt >= high_min) begin
              nxt_s.seq = dphc_pkg::DPHC_SEQ_PATTERN;
              nxt_s.bit_cnt = 4'h1;
              nxt_s.pat = pat_next;
            end
            nxt_s.high_cnt = 8'h00;
          end
        end
        dphc_pkg::DPHC_SEQ_PATTERN: begin
          nxt_s.pat = pat_next;
          nxt_s.bit_cnt = s_ff.bit_cnt + 4'h1;
          if (s_ff.bit_cnt == 4'hF) begin
            if ((s_ff.port == dphc_pkg::DPHC_PORT_JTAG && pat_next == `DPHC_SEQ_TO_SWD) ||
                (s_ff.port == dphc_pkg::DPHC_PORT_SWD && pat_next == `DPHC_SEQ_TO_JTAG)) begin
              nxt_s.seq = dphc_pkg::DPHC_SEQ_TAIL;
              nxt_s.high_cnt = 8'h00;
            end else begin
              nxt_s.seq = dphc_pkg::DPHC_SEQ_WAIT;
              nxt_s.high_cnt = tms ? 8'h01 : 8'h00;
            end
          end
        end
        dphc_pkg::DPHC_SEQ_TAIL: begin
          if (tms) begin
            nxt_s.high_cnt = s_ff.high_cnt + 8'h01;
            if (s_ff.high_cnt + 8'h01 >= high_min) begin
              nxt_s.seq = dphc_pkg::DPHC_SEQ_WAIT;
              nxt_s.port = (s_ff.port == dphc_pkg::DPHC_PORT_JTAG) ?
                dphc_pkg::DPHC_PORT_SWD : dphc_pkg::DPHC_PORT_JTAG;
            end
          end else begin
            nxt_s.seq = dphc_pkg::DPHC_SEQ_WAIT;
            nxt_s.high_cnt = 8'h00;
          end
        end
        default: begin
          nxt_s.seq = dphc_pkg::DPHC_SEQ_WAIT;
        end
      endcase
    end

    // Boundary-scan TAP ahead of the core TAP.
    if (tap_if.tap_reset) begin
      nxt_s.ir = `DPHC_IR_IDCODE;
    end else if (tck_rise && jtag_on) begin
      case (tap_if.state)
        dphc_pkg::DPHC_TLR: nxt_s.ir = `DPHC_IR_IDCODE;
        dphc_pkg::DPHC_CAP_IR: nxt_s.ir_sh = `DPHC_IR_CAPTURE;
        dphc_pkg::DPHC_SH_IR: nxt_s.ir_sh = {tdi, s_ff.ir_sh[4:1]};
        dphc_pkg::DPHC_UPD_IR: nxt_s.ir = s_ff.ir_sh;
        dphc_pkg::DPHC_CAP_DR: nxt_s.dr_sh = (s_ff.ir == `DPHC_IR_IDCODE) ? BSCAN_IDCODE : 32'h00000000;
        dphc_pkg::DPHC_SH_DR: begin
          if (s_ff.ir == `DPHC_IR_IDCODE) begin
            nxt_s.dr_sh = {tdi, s_ff.dr_sh[31:1]};
          end else begin
            nxt_s.dr_sh[0] = tdi;
          end
        end
        default: nxt_s.ir = s_ff.ir;
      endcase
    end
    if (tck_fall && jtag_on) begin
      nxt_s.bsd_out = (tap_if.state == dphc_pkg::DPHC_SH_IR) ? s_ff.ir_sh[0] : s_ff.dr_sh[0];
    end

    // Data-out pin and serial-wire data pin.
    if (trace_on) begin
      nxt_s.dout = async_trace_out;
      nxt_s.dout_oe = 1'b1;
    end else if (tck_fall && jtag_on) begin
      nxt_s.dout = core_tap_tdo;
      nxt_s.dout_oe = (tap_if.state == dphc_pkg::DPHC_SH_IR) || (tap_if.state == dphc_pkg::DPHC_SH_DR);
    end else if (!jtag_on) begin
      nxt_s.dout_oe = 1'b0;
    end
    nxt_s.swdio_out = swd_dio_out;
    nxt_s.swdio_oe = swd_dio_oe & ~jtag_on & ~s_ff.pincfg[`DPHC_PINCFG_OFF];

    // Halt request kept through system reset.
    if (dbg_halt_req) begin
      nxt_s.halt_pend = 1'b1;
    end else if (core_halted && !sys_reset) begin
      nxt_s.halt_pend = 1'b0;
    end

    // Standby exit under hold produces a system reset request.
    nxt_s.standby_prev = in_standby;
    nxt_s.standby_rst = s_ff.standby_prev & ~in_standby & s_ff.ctl[`DPHC_BIT_STANDBY_KEEP];

    // Register writes and registered read data.
    if (reg_wr) begin
      case (reg_addr)
        `DPHC_OFS_HOLD_CTL: nxt_s.ctl = reg_wdata & `DPHC_HOLD_CTL_WMASK;
        `DPHC_OFS_PIN_CFG: nxt_s.pincfg = reg_wdata[1:0];
        default: nxt_s.ctl = s_ff.ctl;
      endcase
    end
    nxt_s.rdata = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        `DPHC_OFS_IDENTITY: nxt_s.rdata = ID_REG_VALUE;
        `DPHC_OFS_HOLD_CTL: nxt_s.rdata = s_ff.ctl;
        `DPHC_OFS_PIN_CFG: nxt_s.rdata = {30'h00000000, s_ff.pincfg};
        `DPHC_OFS_STATUS: nxt_s.rdata = {29'h00000000, s_ff.halt_pend, core_halted, ~jtag_on};
        default: nxt_s.rdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // State register, cleared by power-on reset only.
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_ff <= '{
        tck_sync: 3'h0, tms_sync: 2'h3, tdi_sync: 2'h3, trst_sync: 2'h3,
        port: dphc_pkg::DPHC_PORT_JTAG,
        seq: dphc_pkg::DPHC_SEQ_WAIT, high_cnt: 8'h00, bit_cnt: 4'h0, pat: 16'h0000,
        ir_sh: 5'h00, ir: `DPHC_IR_IDCODE, dr_sh: 32'h00000000, bsd_out: 1'b0,
        dout: 1'b0, dout_oe: 1'b0, swdio_out: 1'b0, swdio_oe: 1'b0,
        ctl: `DPHC_HOLD_CTL_RESET, pincfg: `DPHC_PINCFG_RESET,
        halt_pend: 1'b0, standby_prev: 1'b0, standby_rst: 1'b0, rdata: 32'h00000000
      };
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------
  // Pin ownership and link outputs.
  // ----------------------------------------
  assign own_clock_pin = ~s_ff.pincfg[`DPHC_PINCFG_OFF];
  assign own_mode_select_pin = ~s_ff.pincfg[`DPHC_PINCFG_OFF];
  assign own_data_in_pin = jtag_on;
  assign own_data_out_pin = jtag_on | trace_on;
  assign own_tap_reset_pin = jtag_on & ~s_ff.pincfg[`DPHC_PINCFG_NO_TRST];
  assign swd_active = ~jtag_on;
  assign link_clk_rise = tck_rise;
  assign link_clk_fall = tck_fall;
  assign link_mode_sel = tms;
  assign core_tap_tdi = s_ff.bsd_out;
  assign dbg_mode_select_pin_out = s_ff.swdio_out;
  assign dbg_mode_select_pin_oe = s_ff.swdio_oe;
  assign dbg_data_out_pin = s_ff.dout;
  assign dbg_data_out_pin_oe = s_ff.dout_oe;
  assign reg_rdata = s_ff.rdata;

  // ----------------------------------------
  // Halt, power-mode and freeze outputs.
  // ----------------------------------------
  assign core_halt_req = s_ff.halt_pend & ~sys_reset;
  assign clock_from_internal_rc_8mhz_clock = (in_standby & s_ff.ctl[`DPHC_BIT_STANDBY_KEEP]) |
    (in_deepsleep & s_ff.ctl[`DPHC_BIT_DEEPSLEEP_KEEP]);
  assign keep_bus_clock = clock_from_internal_rc_8mhz_clock | (in_sleep & s_ff.ctl[`DPHC_BIT_SLEEP_KEEP]);
  assign standby_exit_reset = s_ff.standby_rst;
  assign timer_freeze = {s_ff.ctl[31:25], s_ff.ctl[20:17], s_ff.ctl[13:10]} & {15{core_halted}};
  assign smbus_timeout_freeze = {s_ff.ctl[22], s_ff.ctl[16], s_ff.ctl[15]} & {3{core_halted}};
  assign can_rx_freeze = {s_ff.ctl[3], s_ff.ctl[21], s_ff.ctl[14]} & {3{core_halted}};
  assign free_watchdog_freeze = s_ff.ctl[`DPHC_BIT_FREE_WDG] & core_halted;
  assign window_watchdog_freeze = s_ff.ctl[`DPHC_BIT_WINDOW_WDG] & core_halted;
endmodule // dphc_top

// >>> test/dphc_checker.sv
`timescale 1ns/1ns
// ----------------------------------------
// Port checker.
// ----------------------------------------
module dphc_checker #(
  parameter logic [31:0] ID_REG_VALUE = 32'h00002001
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sys_reset,
  input wire logic dbg_halt_req,
  input wire logic core_halted,
  input wire logic core_halt_req,
  input wire logic in_standby,
  input wire logic standby_exit_reset,
  input wire logic swd_active,
  input wire logic own_data_in_pin,
  input wire logic own_tap_reset_pin,
  input wire logic dbg_mode_select_pin_oe,
  input wire logic link_clk_rise,
  input wire logic link_clk_fall,
  input wire logic [14:0] timer_freeze,
  input wire logic [2:0] smbus_timeout_freeze,
  input wire logic [2:0] can_rx_freeze,
  input wire logic free_watchdog_freeze,
  input wire logic window_watchdog_freeze,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_halt_asked;
    (dbg_halt_req && !core_halted) ##1 (!sys_reset && !core_halted);
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("Read data not zero while idle.");
  a_id_const: assert property ($past(reg_rd) && $past(reg_addr) == 8'h00 |-> reg_rdata == ID_REG_VALUE)
    else $error("Identity read wrong.");
  a_ctl_reserved: assert property ($past(reg_rd) && $past(reg_addr) == 8'h04 |->
    (reg_rdata & 32'h018000D0) == 32'h0)
    else $error("Reserved control bits set.");
  a_freeze_halted: assert property (!core_halted |-> {timer_freeze, smbus_timeout_freeze, can_rx_freeze,
    free_watchdog_freeze, window_watchdog_freeze} == 23'h0)
    else $error("Freeze while running.");
  a_halt_in_reset: assert property (sys_reset |-> !core_halt_req)
    else $error("Halt request during system reset.");
  a_halt_kept: assert property (s_halt_asked |-> core_halt_req)
    else $error("Halt request lost.");
  a_oe_jtag: assert property (!swd_active && !$past(swd_active) |-> !dbg_mode_select_pin_oe)
    else $error("Mode pin driven in JTAG mode.");
  a_pins_jtag: assert property (own_data_in_pin == !swd_active)
    else $error("Data-in pin ownership wrong.");
  a_trst_own: assert property (own_tap_reset_pin |-> own_data_in_pin)
    else $error("Reset pin held outside JTAG.");
  a_edge_pulse: assert property (link_clk_rise |-> !link_clk_fall ##1 !link_clk_rise)
    else $error("Link edge pulse wrong.");
  a_stby_exit: assert property (standby_exit_reset |-> !in_standby && ($past(in_standby, 2) ||
    $past(in_standby, 3) || $past(in_standby, 4)) ##1 !standby_exit_reset)
    else $error("Standby exit reset wrong.");
endmodule // dphc_checker
bind dphc_top dphc_checker #(.ID_REG_VALUE(ID_REG_VALUE)) u_checker (.*);

// >>> test/dphc_probe.sv
`timescale 1ns/1ns
// ----------------------------------------
// Debug probe; its clock stands low between frames.
// ----------------------------------------
module dphc_probe (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo
);
  logic last_tdo;
  initial begin
    {tck, tms, tdi, last_tdo} = 4'h0;
    trst_n = 1'b1;
  end
  task automatic cyc(input logic m, input logic d);
    tms = m;
    tdi = d;
    #400;
    tck = 1'b1;
    #400;
    last_tdo = tdo;
    tck = 1'b0;
  endtask
  task automatic switch_seq(input logic [15:0] pat, input int n);
    repeat (n) cyc(1'b1, 1'b0);
    for (int i = 0; i < 16; i++) cyc(pat[i], 1'b0);
    repeat (n) cyc(1'b1, 1'b0);
  endtask
  task automatic trst_pulse;
    trst_n = 1'b0;
    #800;
    trst_n = 1'b1;
  endtask
endmodule // dphc_probe

// >>> test/dphc_bench.sv
`timescale 1ns/1ns
module dphc_bench;
  localparam int SEQ = 5;
  // Both identity values are arbitrary.
  localparam logic [31:0] IDV = 32'h00002001;
  localparam logic [31:0] BSID = 32'h00001001;
  logic clk_sys, rst, sys_reset, core_tap_tdo, swd_dio_out, swd_dio_oe, async_trace_out;
  logic dbg_halt_req, core_halted, in_sleep, in_deepsleep, in_standby, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic dbg_mode_select_pin_out, dbg_mode_select_pin_oe, dbg_data_out_pin, dbg_data_out_pin_oe;
  logic own_clock_pin, own_mode_select_pin, own_data_in_pin, own_data_out_pin, own_tap_reset_pin;
  logic swd_active, link_clk_rise, link_clk_fall, link_mode_sel, core_tap_tdi, core_halt_req;
  logic keep_bus_clock, clock_from_internal_rc_8mhz_clock, standby_exit_reset;
  logic free_watchdog_freeze, window_watchdog_freeze;
  logic [14:0] timer_freeze;
  logic [2:0] smbus_timeout_freeze, can_rx_freeze;
  wire logic dbg_clock_pin, dbg_mode_select_pin_in, dbg_data_in_pin, tap_reset_n_pin, tms_drv;
  wire logic [22:0] frz_seen;
  int miscompares, n_compared;
  dphc_top #(.SEQ_HIGH_MIN(SEQ), .BSCAN_IDCODE(BSID), .ID_REG_VALUE(IDV)) dut (.*);
  dphc_probe probe (.tck(dbg_clock_pin), .tms(tms_drv), .tdi(dbg_data_in_pin), .trst_n(tap_reset_n_pin),
    .tdo(dbg_data_out_pin_oe ? dbg_data_out_pin : ~dbg_data_out_pin));
  assign dbg_mode_select_pin_in = dbg_mode_select_pin_oe ? dbg_mode_select_pin_out : tms_drv;
  assign frz_seen = {timer_freeze, smbus_timeout_freeze, can_rx_freeze, free_watchdog_freeze,
    window_watchdog_freeze};
  // One-bit core bypass stage behind the boundary TAP.
  always @(posedge clk_sys) begin
    if (rst) begin
      core_tap_tdo <= 1'b0;
    end else if (link_clk_rise) begin
      core_tap_tdo <= core_tap_tdi;
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // Shared tasks.
  // ----------------------------------------
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic settle;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  function automatic logic [22:0] frz(input logic [31:0] c);
    return {c[31:25], c[20:17], c[13:10], c[22], c[16], c[15], c[3], c[21], c[14], c[8], c[9]};
  endfunction
  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  task automatic t_regs;
    rd(8'h00, rv);
    chk(rv, IDV);
    rd(8'h04, rv);
    chk(rv, 32'h0);
    wr(8'h00, 32'h5A5A5A5A);
    rd(8'h00, rv);
    chk(rv, IDV);
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04, rv);
    chk(rv, 32'hFE7FFF2F);
    rd(8'h10, rv);
    chk(rv, 32'h0);
    @(posedge clk_sys) sys_reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_reset <= 1'b0;
    rd(8'h04, rv);
    chk(rv, 32'hFE7FFF2F);
    $display("registers done");
  endtask
  task automatic t_freeze;
    logic [31:0] vals [4];
    vals = '{32'hFE7FFF2F, 32'h00000400, 32'h82408108, 32'h00000200};
    foreach (vals[i]) begin
      wr(8'h04, vals[i]);
      for (int h = 0; h < 2; h++) begin
        @(posedge clk_sys) core_halted <= h[0];
        settle();
        chk(frz_seen, h[0] ? frz(vals[i]) : 23'h0);
      end
    end
    @(posedge clk_sys) core_halted <= 1'b0;
    $display("freeze done");
  endtask
  task automatic t_power;
    int n;
    n = 0;
    wr(8'h04, 32'h00000007);
    @(posedge clk_sys) in_sleep <= 1'b1;
    settle();
    chk(keep_bus_clock, 1'b1);
    @(posedge clk_sys) in_sleep <= 1'b0;
    @(posedge clk_sys) in_deepsleep <= 1'b1;
    settle();
    chk(clock_from_internal_rc_8mhz_clock, 1'b1);
    @(posedge clk_sys) in_deepsleep <= 1'b0;
    @(posedge clk_sys) in_standby <= 1'b1;
    settle();
    chk(clock_from_internal_rc_8mhz_clock, 1'b1);
    @(posedge clk_sys) in_standby <= 1'b0;
    repeat (5) begin
      settle();
      n += (standby_exit_reset === 1'b1);
    end
    chk(n, 1);
    wr(8'h04, 32'h0);
    @(posedge clk_sys) in_sleep <= 1'b1;
    settle();
    chk(keep_bus_clock, 1'b0);
    @(posedge clk_sys) in_sleep <= 1'b0;
    $display("power done");
  endtask
  task automatic t_halt;
    @(posedge clk_sys) sys_reset <= 1'b1;
    @(posedge clk_sys) dbg_halt_req <= 1'b1;
    @(posedge clk_sys) dbg_halt_req <= 1'b0;
    settle();
    chk(core_halt_req, 1'b0);
    @(posedge clk_sys) sys_reset <= 1'b0;
    #1 chk(core_halt_req, 1'b1);
    @(posedge clk_sys) core_halted <= 1'b1;
    settle();
    chk(core_halt_req, 1'b0);
    @(posedge clk_sys) core_halted <= 1'b0;
    @(posedge clk_sys) dbg_halt_req <= 1'b1;
    @(posedge clk_sys) dbg_halt_req <= 1'b0;
    #1 chk(core_halt_req, 1'b1);
    @(posedge clk_sys) core_halted <= 1'b1;
    @(posedge clk_sys) core_halted <= 1'b0;
    #1 chk(core_halt_req, 1'b0);
    $display("halt done");
  endtask
  task automatic t_pins;
    wr(8'h04, 32'h00000100);
    wr(8'h08, 32'h1);
    settle();
    chk({own_tap_reset_pin, own_data_in_pin}, 2'b01);
    wr(8'h08, 32'h2);
    settle();
    chk({own_clock_pin, own_mode_select_pin, own_data_out_pin, swd_active}, 4'b0001);
    wr(8'h08, 32'h0);
    probe.trst_pulse();
    rd(8'h04, rv);
    chk({rv, swd_active}, {32'h00000100, 1'b0});
    $display("pins done");
  endtask
  task automatic t_link;
    logic [31:0] id;
    chk({swd_active, own_data_in_pin, own_tap_reset_pin}, 3'b011);
    probe.switch_seq(16'hE79E, SEQ);
    settle();
    chk({swd_active, own_data_in_pin, own_data_out_pin, own_clock_pin, own_mode_select_pin}, 5'h13);
    @(posedge clk_sys) {swd_dio_oe, swd_dio_out} <= 2'b11;
    settle();
    chk({dbg_mode_select_pin_oe, dbg_mode_select_pin_out}, 2'b11);
    @(posedge clk_sys) {swd_dio_oe, swd_dio_out} <= 2'b00;
    probe.switch_seq(16'hE73C, SEQ);
    settle();
    chk(swd_active, 1'b0);
    for (int i = 0; i < 4; i++) probe.cyc(i == 1, 1'b0);
    for (int i = 1; i < 34; i++) begin
      probe.cyc(1'b0, 1'b1);
      if (i > 1) id[i-2] = probe.last_tdo;
    end
    chk({id, dbg_data_out_pin_oe}, {BSID, 1'b1});
    for (int i = 0; i < 3; i++) probe.cyc(i < 2, 1'b0);
    wr(8'h04, 32'h00000020);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys) async_trace_out <= i[0];
      settle();
      settle();
      chk({own_data_out_pin, dbg_data_out_pin_oe, dbg_data_out_pin, link_mode_sel}, {2'b11, i[0], 1'b0});
    end
    $display("link done");
  endtask
  initial begin
    {sys_reset, swd_dio_out, swd_dio_oe, async_trace_out, dbg_halt_req, core_halted} = 6'h0;
    {in_sleep, in_deepsleep, in_standby, reg_wr, reg_rd, reg_addr, reg_wdata} = 45'h0;
    miscompares = 0;
    n_compared = 0;
    rst = 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    t_regs();
    t_freeze();
    t_power();
    t_halt();
    t_pins();
    t_link();
    end_sim();
  end
  initial begin
    #1000000;
    miscompares++;
    end_sim();
  end
endmodule // dphc_bench
